// [rtl/mirror_pkg.sv]
// Constants, register layouts and carrier types for the mirror probe selector.
package mirror_pkg;

    // Probe and port geometry.
    localparam int NUM_PROBES = 3;
    localparam int PROBE_W    = 2;
    localparam int NUM_PORTS  = 64;
    localparam int PORT_W     = 6;
    localparam int CPU_W      = 4;
    localparam int CPU_IDX_W  = 2;
    localparam int VID_W      = 12;

    // Bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;
    localparam int BYTE_W = 8;

    // Address fields: a block of four words per probe, block 0 is global.
    localparam int BLK_LSB  = 4;
    localparam int BLK_W    = 4;
    localparam int WORD_LSB = 2;
    localparam int WORD_W   = 2;
    localparam logic [BLK_W-1:0]  BLK_GLOBAL   = 4'h0;
    localparam logic [BLK_W-1:0]  BLK_FIRST    = 4'h1;
    localparam logic [WORD_W-1:0] WORD_CTRL    = 2'h0;
    localparam logic [WORD_W-1:0] WORD_STATUS  = 2'h1;
    localparam logic [WORD_W-1:0] WORD_SETUP   = 2'h0;
    localparam logic [WORD_W-1:0] WORD_MASK_LO = 2'h1;
    localparam logic [WORD_W-1:0] WORD_MASK_HI = 2'h2;
    localparam logic [WORD_W-1:0] WORD_DEST    = 2'h3;

    // Writable bits; everything else reads as zero.
    localparam logic [DATA_W-1:0] SETUP_RW_MASK = 32'h07FF_FFFF;
    localparam logic [DATA_W-1:0] DEST_RW_MASK  = 32'h0000_1FFF;
    localparam int CTRL_FLOOD_BIT = 0;

    // Bit positions inside the direction and station mode fields.
    localparam int DIR_TX  = 0;
    localparam int DIR_RX  = 1;
    localparam int STA_DST = 0;
    localparam int STA_SRC = 1;

    // VLAN filter modes; codes 0 and 3 pass every frame.
    localparam logic [1:0] VLAN_FLAG = 2'h1;
    localparam logic [1:0] VLAN_VID  = 2'h2;

    typedef struct packed {
        logic [4:0]       spare;
        logic [CPU_W-1:0] rx_cpu_virtual_mask;
        logic [CPU_W-1:0] cpu_set;
        logic [VID_W-1:0] vlan_filter_id;
        logic             rx_physical_port_sel;
        logic [1:0]       vlan_filter_mode;
        logic [1:0]       station_filter_mode;
        logic [1:0]       direction;
    } setup_t;

    typedef struct packed {
        logic [18:0]       spare;
        logic              remote_tag_ena;
        logic [PORT_W-1:0] tx_edit_port;
        logic [PORT_W-1:0] copy_destination_port;
    } dest_t;

    typedef struct packed {
        setup_t            setup;
        logic [DATA_W-1:0] mask_hi;
        logic [DATA_W-1:0] mask_lo;
        dest_t             dest;
    } probe_reg_t;

    typedef struct packed {
        logic [PORT_W-1:0]    rx_port;
        logic [PORT_W-1:0]    masq_port;
        logic                 from_cpu;
        logic [CPU_IDX_W-1:0] cpu_idx;
        logic                 tx_valid;
        logic [PORT_W-1:0]    tx_port;
        logic [CPU_W-1:0]     cpu_dst_set;
        logic [VID_W-1:0]     vid;
        logic                 vlan_entry_mirror_flag;
        logic                 src_flag;
        logic                 dst_flag;
        logic                 flooded;
        logic                 cls_valid;
        logic [PROBE_W-1:0]   cls_probe;
    } frame_t;

    typedef struct packed {
        logic               copy;
        logic [PROBE_W-1:0] probe;
        logic [PORT_W-1:0]  copy_destination_port;
        logic               rx_copy;
        logic               add_qtag;
        logic [PORT_W-1:0]  tx_edit_port;
    } decision_t;

endpackage

// [rtl/probe_match.sv]
// Filter evaluation of one mirror probe against one frame.
`timescale 1ns/10ps
module probe_match
    import mirror_pkg::*;
#(
    parameter int INDEX = 0
)
(
    // Probe setup.
    input  probe_reg_t cfg,
    input  logic       flooded_copy_enable,
    // Frame under decision.
    input  frame_t     frm,
    // Result.
    output logic       hit,
    output logic       rx_side
);

    logic [NUM_PORTS-1:0] mask;
    logic [PORT_W-1:0]    rx_sel;
    logic [1:0]           dir;
    logic [1:0]           sta;
    logic                 rx_hit;
    logic                 tx_hit;
    logic                 vlan_ok;
    logic                 sta_ok;
    logic                 cls_sel;
    logic                 cls_hit;

    if (INDEX < 0 || INDEX >= NUM_PROBES) begin : g_bad_index
        $error("probe_match: INDEX out of range");
    end

    assign dir    = cfg.setup.direction;
    assign sta    = cfg.setup.station_filter_mode;
    assign mask   = {cfg.mask_hi, cfg.mask_lo};
    assign rx_sel = cfg.setup.rx_physical_port_sel ? frm.rx_port : frm.masq_port;

    // On the receive side, a frame injected by the CPU is judged by the CPU mask, never by the port mask.
    assign rx_hit = dir[DIR_RX] & (frm.from_cpu ? cfg.setup.rx_cpu_virtual_mask[frm.cpu_idx]
                                                : mask[rx_sel]);
    assign tx_hit = dir[DIR_TX] & ((frm.tx_valid & mask[frm.tx_port])
                                   | (|(cfg.setup.cpu_set & frm.cpu_dst_set)));

    always_comb begin
        unique case (cfg.setup.vlan_filter_mode)
            VLAN_FLAG: vlan_ok = frm.vlan_entry_mirror_flag;
            VLAN_VID:  vlan_ok = (frm.vid == cfg.setup.vlan_filter_id);
            default:   vlan_ok = 1'b1;
        endcase
    end

    assign sta_ok = (~sta[STA_SRC] | frm.src_flag)
                  & (~sta[STA_DST] | frm.dst_flag | (frm.flooded & flooded_copy_enable));

    assign cls_sel = frm.cls_valid & (frm.cls_probe == PROBE_W'(INDEX));
    assign cls_hit = dir[DIR_RX] | (dir[DIR_TX] & frm.tx_valid);

    assign hit     = cls_sel ? cls_hit : ((rx_hit | tx_hit) & vlan_ok & sta_ok);
    assign rx_side = cls_sel ? dir[DIR_RX] : rx_hit;

endmodule

// [rtl/traffic_mirror_probe_select.sv]
// Per-frame mirror decision with three probes and an Avalon-MM register slave.
`timescale 1ns/10ps
module traffic_mirror_probe_select
    import mirror_pkg::*;
#(
    parameter int CNT_W = 32
)
(
    // Clock and reset.
    input  logic              clk_sys,
    input  logic              reset_n,
    // Avalon-MM register slave.
    input  logic [ADDR_W-1:0] avs_address,
    input  logic              avs_read,
    input  logic              avs_write,
    input  logic [DATA_W-1:0] avs_writedata,
    input  logic [BE_W-1:0]   avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic              avs_waitrequest,
    // Frame descriptors from the forwarding pipeline.
    input  logic              frm_valid,
    output logic              frm_ready,
    input  frame_t            frm,
    // Mirror decisions towards queueing and rewriter.
    output logic              dec_valid,
    input  logic              dec_ready,
    output decision_t         dec
);

    if (CNT_W < 1 || CNT_W > DATA_W) begin : g_bad_cnt
        $error("traffic_mirror_probe_select: CNT_W must be 1 to DATA_W");
    end

    typedef struct packed {
        probe_reg_t [NUM_PROBES-1:0] cfg;
        logic                        flood_ena;
        logic [CNT_W-1:0]            copy_cnt;
        logic                        ack;
        logic [DATA_W-1:0]           rdata;
        logic                        out_valid;
        decision_t                   out;
        logic [NUM_PROBES-1:0]       hits;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // Bus decode.
    logic [BLK_W-1:0]   blk;
    logic [WORD_W-1:0]  word;
    logic               slot_ok;
    logic [PROBE_W-1:0] slot;
    logic               bus_req;
    logic [DATA_W-1:0]  rd_word;
    logic [DATA_W-1:0]  wr_word;

    // Frame path.
    logic [NUM_PROBES-1:0] hits;
    logic [NUM_PROBES-1:0] rx_sides;
    logic                  win_any;
    logic [PROBE_W-1:0]    win_idx;
    dest_t                 dest_sel;
    logic                  fr_take;
    decision_t             dec_new;

    function automatic logic [DATA_W-1:0] be_merge(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [BE_W-1:0]   be
    );
        logic [DATA_W-1:0] r;
        r = old_w;
        for (int i = 0; i < BE_W; i++) begin
            if (be[i]) begin
                r[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
            end
        end
        return r;
    endfunction

    function automatic logic blk_is_probe(input logic [BLK_W-1:0] b);
        return (b >= BLK_FIRST) && (b < BLK_FIRST + BLK_W'(NUM_PROBES));
    endfunction

    assign blk     = avs_address[BLK_LSB +: BLK_W];
    assign word    = avs_address[WORD_LSB +: WORD_W];
    assign slot_ok = blk_is_probe(blk);
    assign slot    = PROBE_W'(blk - BLK_FIRST);
    assign bus_req = avs_read | avs_write;

    // One wait state: the word is fetched while waitrequest is high.
    assign avs_waitrequest = bus_req & ~st_r.ack;
    assign avs_readdata    = st_r.rdata;

    always_comb begin
        rd_word = '0;
        if (blk == BLK_GLOBAL) begin
            if (word == WORD_CTRL) begin
                rd_word[CTRL_FLOOD_BIT] = st_r.flood_ena;
            end else if (word == WORD_STATUS) begin
                rd_word = DATA_W'(st_r.copy_cnt);
            end
        end else if (slot_ok) begin
            unique case (word)
                WORD_SETUP:   rd_word = st_r.cfg[slot].setup;
                WORD_MASK_LO: rd_word = st_r.cfg[slot].mask_lo;
                WORD_MASK_HI: rd_word = st_r.cfg[slot].mask_hi;
                WORD_DEST:    rd_word = st_r.cfg[slot].dest;
            endcase
        end
    end

    assign wr_word = be_merge(rd_word, avs_writedata, avs_byteenable);

    // Probe evaluation.
    for (genvar p = 0; p < NUM_PROBES; p++) begin : g_probe
        probe_match #(
            .INDEX(p)
        ) u_match (
            .cfg                (st_r.cfg[p]),
            .flooded_copy_enable(st_r.flood_ena),
            .frm                (frm),
            .hit                (hits[p]),
            .rx_side            (rx_sides[p])
        );
    end

    always_comb begin
        win_any = 1'b0;
        win_idx = '0;
        for (int i = 0; i < NUM_PROBES; i++) begin
            if (hits[i]) begin
                win_any = 1'b1;
                win_idx = PROBE_W'(i);
            end
        end
    end

    assign dest_sel = st_r.cfg[win_idx].dest;

    always_comb begin
        dec_new                       = '0;
        dec_new.copy                  = win_any;
        dec_new.probe                 = win_idx;
        dec_new.copy_destination_port = dest_sel.copy_destination_port;
        dec_new.rx_copy               = rx_sides[win_idx];
        dec_new.add_qtag              = dest_sel.remote_tag_ena;
        dec_new.tx_edit_port          = dest_sel.tx_edit_port;
        if (!win_any) begin
            dec_new = '0;
        end
    end

    // A single output stage; a stalled consumer stalls the pipeline.
    assign frm_ready = ~st_r.out_valid | dec_ready;
    assign fr_take   = frm_valid & frm_ready;
    assign dec_valid = st_r.out_valid;
    assign dec       = st_r.out;

    always_comb begin
        st_nxt = st_r;

        st_nxt.ack = bus_req & ~st_r.ack;
        if (bus_req && !st_r.ack) begin
            st_nxt.rdata = avs_read ? rd_word : '0;
        end

        // Writes land on the edge where waitrequest is low.
        if (avs_write && st_r.ack) begin
            if (blk == BLK_GLOBAL) begin
                if (word == WORD_CTRL) begin
                    st_nxt.flood_ena = wr_word[CTRL_FLOOD_BIT];
                end
            end else if (slot_ok) begin
                unique case (word)
                    WORD_SETUP:   st_nxt.cfg[slot].setup   = setup_t'(wr_word & SETUP_RW_MASK);
                    WORD_MASK_LO: st_nxt.cfg[slot].mask_lo = wr_word;
                    WORD_MASK_HI: st_nxt.cfg[slot].mask_hi = wr_word;
                    WORD_DEST:    st_nxt.cfg[slot].dest    = dest_t'(wr_word & DEST_RW_MASK);
                endcase
            end
        end

        if (fr_take) begin
            st_nxt.out_valid = 1'b1;
            st_nxt.out       = dec_new;
            st_nxt.hits      = hits;
            if (win_any) begin
                st_nxt.copy_cnt = st_r.copy_cnt + CNT_W'(1);
            end
        end else if (dec_ready) begin
            st_nxt.out_valid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Checks.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    logic plain0;
    assign plain0 = !(frm.cls_valid && frm.cls_probe == '0);

    logic plain1;
    assign plain1 = !(frm.cls_valid && frm.cls_probe == PROBE_W'(1));

    // Whole port masks as one vector, since a concatenation cannot be indexed in place.
    logic [NUM_PORTS-1:0] mask0;
    logic [NUM_PORTS-1:0] mask1;
    assign mask0 = {st_r.cfg[0].mask_hi, st_r.cfg[0].mask_lo};
    assign mask1 = {st_r.cfg[1].mask_hi, st_r.cfg[1].mask_lo};

    sequence s_bus_req;
        bus_req && !st_r.ack;
    endsequence

    sequence s_bus_done;
        !avs_waitrequest ##1 (!bus_req || avs_waitrequest);
    endsequence

    sequence s_take_hit;
        fr_take && win_any;
    endsequence

    a_bus_answer: assert property (s_bus_req |=> s_bus_done)
        else $error("bus request not answered after one wait state");

    a_probe_priority: assert property (
        s_take_hit |=> st_r.out.copy && st_r.hits[st_r.out.probe]
                       && ((st_r.hits >> st_r.out.probe) >> 1) == '0)
        else $error("lower probe won over a higher matching one");

    a_no_hit_no_copy: assert property (
        fr_take && !win_any |=> dec_valid && !dec.copy)
        else $error("copy made without a matching probe");

    a_dir_zero_quiet: assert property (
        st_r.cfg[0].setup.direction == '0 |-> !hits[0])
        else $error("probe with zero direction matched");

    a_rx_port_hit: assert property (
        plain0 && !frm.from_cpu && st_r.cfg[0].setup.direction[DIR_RX]
        && st_r.cfg[0].setup.rx_physical_port_sel
        && mask0[frm.rx_port]
        && st_r.cfg[0].setup.vlan_filter_mode == '0
        && st_r.cfg[0].setup.station_filter_mode == '0 |-> hits[0])
        else $error("receive port mirror missed");

    a_tx_cpu_hit: assert property (
        plain0 && st_r.cfg[0].setup.direction[DIR_TX]
        && (st_r.cfg[0].setup.cpu_set & frm.cpu_dst_set) != '0
        && st_r.cfg[0].setup.vlan_filter_mode == '0
        && st_r.cfg[0].setup.station_filter_mode == '0 |-> hits[0])
        else $error("CPU destination mirror missed");

    a_vid_filter: assert property (
        plain0 && st_r.cfg[0].setup.vlan_filter_mode == VLAN_VID
        && frm.vid != st_r.cfg[0].setup.vlan_filter_id |-> !hits[0])
        else $error("frame of another VLAN passed the VID filter");

    a_vlan_flag: assert property (
        plain0 && st_r.cfg[0].setup.vlan_filter_mode == VLAN_FLAG
        && !frm.vlan_entry_mirror_flag |-> !hits[0])
        else $error("unflagged VLAN passed the flag filter");

    a_src_station: assert property (
        plain0 && st_r.cfg[0].setup.station_filter_mode[STA_SRC]
        && !frm.src_flag |-> !hits[0])
        else $error("unflagged source passed the station filter");

    a_dst_flood: assert property (
        plain0 && st_r.cfg[0].setup.station_filter_mode[STA_DST]
        && !frm.dst_flag && !(frm.flooded && st_r.flood_ena) |-> !hits[0])
        else $error("unflagged destination passed the station filter");

    a_cls_override: assert property (
        !plain0 && st_r.cfg[0].setup.direction[DIR_RX] |-> hits[0] && rx_sides[0])
        else $error("classification-selected probe did not mirror");

    a_dest_port: assert property (
        s_take_hit |=> dec.copy_destination_port == $past(dest_sel.copy_destination_port))
        else $error("copy sent to the wrong destination port");

    a_rx_tag: assert property (
        (s_take_hit and rx_sides[win_idx]) |=> dec.rx_copy
        && dec.add_qtag == $past(dest_sel.remote_tag_ena))
        else $error("receive copy tag option wrong");

    a_tx_edit: assert property (
        (s_take_hit and !rx_sides[win_idx]) |=> !dec.rx_copy
        && dec.tx_edit_port == $past(dest_sel.tx_edit_port))
        else $error("transmit copy edit port wrong");

    a_copy_count: assert property (
        s_take_hit |=> st_r.copy_cnt == $past(st_r.copy_cnt) + CNT_W'(1))
        else $error("copy counter did not advance");

    a_out_hold: assert property (
        dec_valid && !dec_ready |=> dec_valid && $stable(dec))
        else $error("decision changed while stalled");

    a_tx_port_hit: assert property (
        plain0 && st_r.cfg[0].setup.direction[DIR_TX] && frm.tx_valid && mask0[frm.tx_port]
        && st_r.cfg[0].setup.vlan_filter_mode == '0
        && st_r.cfg[0].setup.station_filter_mode == '0 |-> hits[0])
        else $error("transmit port mirror missed");

    a_cpu_rx_hit: assert property (
        plain0 && frm.from_cpu && st_r.cfg[0].setup.direction[DIR_RX]
        && st_r.cfg[0].setup.rx_cpu_virtual_mask[frm.cpu_idx]
        && st_r.cfg[0].setup.vlan_filter_mode == '0
        && st_r.cfg[0].setup.station_filter_mode == '0 |-> hits[0] && rx_sides[0])
        else $error("CPU injected frame not mirrored");

    a_masq_port: assert property (
        plain1 && !frm.from_cpu && !st_r.cfg[1].setup.direction[DIR_TX]
        && !st_r.cfg[1].setup.rx_physical_port_sel && !mask1[frm.masq_port] |-> !hits[1])
        else $error("receive match ignored the masqueraded port");

    // Unmapped words read as zero so that software can walk the map safely.
    a_read_unmapped: assert property (
        avs_read && !st_r.ack && blk != BLK_GLOBAL && !slot_ok |=> avs_readdata == '0)
        else $error("unmapped word read as nonzero");

    a_flood_write: assert property (
        avs_write && st_r.ack && avs_byteenable[0] && blk == BLK_GLOBAL && word == WORD_CTRL
        |=> st_r.flood_ena == $past(avs_writedata[CTRL_FLOOD_BIT]))
        else $error("flood copy enable not written");

endmodule

// [verification/mirror_sink.sv]
// Decision consumer standing in for queueing and the rewriter, with optional stalls.
`timescale 1ns/10ps
module mirror_sink
    import mirror_pkg::*;
(
    // Clock and reset.
    input  logic      clk_sys,
    input  logic      reset_n,
    // Decision stream.
    input  logic      dec_valid,
    input  decision_t dec,
    output logic      dec_ready,
    // Stall control and hold monitor.
    input  logic      slow,
    output logic      unstable
);
    logic [1:0] phase_r;
    logic       waiting_r;
    decision_t  last_r;

    // Stalling two cycles in four keeps decisions waiting and frames refused upstream.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_r   <= 2'h0;
            dec_ready <= 1'b0;
            waiting_r <= 1'b0;
            last_r    <= '0;
        end else begin
            phase_r   <= phase_r + 2'h1;
            dec_ready <= !slow || phase_r[1];
            waiting_r <= dec_valid && !dec_ready;
            last_r    <= dec;
        end
    end

    // A decision that was offered but not taken must still be offered unchanged.
    assign unstable = waiting_r && (!dec_valid || dec !== last_r);
endmodule

// [verification/tb.sv]
// Self-checking bench for the mirror probe selector.
`timescale 1ns/10ps
module tb;
    import mirror_pkg::*;
    logic              clk_sys;
    logic              reset_n;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [BE_W-1:0]   avs_byteenable;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic              frm_valid;
    logic              frm_ready;
    frame_t            frm;
    logic              dec_valid;
    logic              dec_ready;
    decision_t         dec;
    logic              slow;
    logic              unstable;
    int                mismatches;
    int                checks;
    int                copies;
    frame_t            f;
    dest_t             dst [NUM_PROBES];
    logic [31:0]       rdv;
    decision_t         expq [$];

    traffic_mirror_probe_select traffic_mirror_probe_select_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frm_valid(frm_valid),
        .frm_ready(frm_ready), .frm(frm), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec(dec)
    );

    mirror_sink mirror_sink_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .dec_valid(dec_valid), .dec(dec),
        .dec_ready(dec_ready), .slow(slow), .unstable(unstable)
    );

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One bus transfer; read data is taken at the edge where waitrequest is seen low.
    task bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_read      <= !is_wr;
        avs_write     <= is_wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        chk(32'(n < 50), 32'h1);
        rdv = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask

    function automatic logic [7:0] pa(input int p, input int w);
        return 8'((p + 1) * 16 + w * 4);
    endfunction

    function automatic logic [31:0] su(input logic [1:0] dir, input logic [1:0] sta, input logic [1:0] vm,
                                       input logic ph, input logic [11:0] vid, input logic [3:0] cs,
                                       input logic [3:0] cm);
        return {5'h0, cm, cs, vid, ph, vm, sta, dir};
    endfunction

    task cfg(input int p, input logic [31:0] s, input logic [31:0] lo, input logic [31:0] hi);
        wr(pa(p, 0), s);
        wr(pa(p, 1), lo);
        wr(pa(p, 2), hi);
        wr(pa(p, 3), 32'(dst[p]));
    endtask

    // Queues the expected decision, then offers the frame until it is taken.
    task send(input frame_t fr, input int p, input logic rx);
        int n;
        decision_t e;
        e = '0;
        if (p >= 0) begin
            e.copy = 1'b1;
            e.probe = PROBE_W'(p);
            e.copy_destination_port = dst[p].copy_destination_port;
            e.rx_copy = rx;
            e.add_qtag = dst[p].remote_tag_ena;
            e.tx_edit_port = dst[p].tx_edit_port;
            copies++;
        end
        expq.push_back(e);
        @(posedge clk_sys);
        frm_valid <= 1'b1;
        frm       <= fr;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (frm_ready !== 1'b1 && n < 50);
        frm_valid <= 1'b0;
    endtask

    always @(posedge clk_sys) begin
        if (reset_n === 1'b1 && unstable !== 1'b0) begin
            chk(32'(unstable), 32'h0);
        end
        if (reset_n === 1'b1 && dec_valid === 1'b1 && dec_ready === 1'b1) begin
            if (expq.size() > 0) begin
                chk(32'(dec), 32'(expq.pop_front()));
            end else begin
                chk(32'(dec), 32'hFFFF_FFFF);
            end
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #300000;
        mismatches++;
        end_of_test();
    end

    initial begin
        reset_n = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hF;
        frm_valid = 1'b0;
        frm = '0;
        slow = 1'b0;
        mismatches = 0;
        checks = 0;
        copies = 0;
        foreach (dst[i]) dst[i] = '0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        rdc(pa(0, 0), 32'h0);
        wr(pa(0, 0), 32'hFFFF_FFFF);
        rdc(pa(0, 0), 32'h07FF_FFFF);
        wr(pa(2, 3), 32'hFFFF_FFFF);
        rdc(pa(2, 3), 32'h0000_1FFF);
        wr(8'h40, 32'h1234_5678);
        rdc(8'h40, 32'h0);
        wr(pa(0, 0), 32'h0);
        dst[1].copy_destination_port = 6'h0B;
        cfg(1, su(2'h2, 2'h0, VLAN_VID, 1'b1, 12'h003, 4'h0, 4'h0), 32'h8, 32'h0);
        f = '0;
        f.rx_port = 6'h03;
        f.masq_port = 6'h03;
        f.vid = 12'h003;
        send(f, 1, 1'b1);
        f.vid = 12'h004;
        send(f, -1, 1'b0);
        f.vid = 12'h003;
        f.rx_port = 6'h02;
        f.masq_port = 6'h02;
        send(f, -1, 1'b0);
        f.rx_port = 6'h05;
        f.masq_port = 6'h03;
        send(f, -1, 1'b0);
        wr(pa(1, 0), su(2'h2, 2'h0, VLAN_VID, 1'b0, 12'h003, 4'h0, 4'h0));
        send(f, 1, 1'b1);
        f.rx_port = 6'h03;
        f.masq_port = 6'h05;
        send(f, -1, 1'b0);
        f.masq_port = 6'h03;
        dst[2].copy_destination_port = 6'h14;
        dst[2].remote_tag_ena = 1'b1;
        cfg(2, su(2'h2, 2'h0, 2'h0, 1'b0, 12'h000, 4'h0, 4'h0), 32'h8, 32'h0);
        send(f, 2, 1'b1);
        wr(pa(2, 0), 32'h0);
        wr(pa(1, 0), 32'h0);
        dst[0].copy_destination_port = 6'h07;
        dst[0].tx_edit_port = 6'h09;
        dst[0].remote_tag_ena = 1'b1;
        cfg(0, su(2'h1, 2'h0, 2'h0, 1'b1, 12'h000, 4'h0, 4'h0), 32'h0, 32'h100);
        f = '0;
        f.tx_valid = 1'b1;
        f.tx_port = 6'd40;
        send(f, 0, 1'b0);
        f.tx_port = 6'd41;
        send(f, -1, 1'b0);
        wr(pa(0, 0), su(2'h1, 2'h0, 2'h0, 1'b1, 12'h000, 4'h4, 4'h0));
        f = '0;
        f.cpu_dst_set = 4'h4;
        send(f, 0, 1'b0);
        f.cpu_dst_set = 4'h2;
        send(f, -1, 1'b0);
        wr(pa(0, 0), su(2'h2, 2'h0, 2'h0, 1'b1, 12'h000, 4'h0, 4'h2));
        f = '0;
        f.from_cpu = 1'b1;
        f.cpu_idx = 2'h1;
        send(f, 0, 1'b1);
        f.cpu_idx = 2'h2;
        send(f, -1, 1'b0);
        slow <= 1'b1;
        cfg(0, su(2'h2, 2'h0, VLAN_FLAG, 1'b1, 12'h000, 4'h0, 4'h0), 32'h1, 32'h0);
        f = '0;
        f.vlan_entry_mirror_flag = 1'b1;
        send(f, 0, 1'b1);
        f.vlan_entry_mirror_flag = 1'b0;
        send(f, -1, 1'b0);
        wr(pa(0, 0), su(2'h2, 2'h2, 2'h0, 1'b1, 12'h000, 4'h0, 4'h0));
        f.src_flag = 1'b1;
        send(f, 0, 1'b1);
        f.src_flag = 1'b0;
        send(f, -1, 1'b0);
        wr(pa(0, 0), su(2'h2, 2'h1, 2'h0, 1'b1, 12'h000, 4'h0, 4'h0));
        f.dst_flag = 1'b1;
        send(f, 0, 1'b1);
        f.dst_flag = 1'b0;
        f.flooded = 1'b1;
        send(f, -1, 1'b0);
        wr(8'h00, 32'h1);
        send(f, 0, 1'b1);
        cfg(0, su(2'h2, 2'h0, VLAN_VID, 1'b1, 12'h3E7, 4'h0, 4'h0), 32'h0, 32'h0);
        f = '0;
        f.cls_valid = 1'b1;
        send(f, 0, 1'b1);
        wr(pa(0, 0), 32'h0);
        send(f, -1, 1'b0);
        repeat (20) @(posedge clk_sys);
        chk(32'(expq.size()), 32'h0);
        rdc(8'h04, 32'(copies));
        end_of_test();
    end
endmodule
